/* rsc_pkg.sv */
// rsc_pkg: constants and carrier types for the readout section control/status register.
// assumes one clock, asynchronous active-high reset, two sections per card.
package rsc_pkg;

  localparam int unsigned RSC_SECTIONS = 2;
  localparam int unsigned RSC_WIDTH    = 32;

  // read-only status positions
  localparam int unsigned RSC_B_LINK_TIMEOUT_XFER  = 0;
  localparam int unsigned RSC_B_DISP_XFER  = 1;
  localparam int unsigned RSC_B_OVF_XFER   = 2;
  localparam int unsigned RSC_B_DISP_TEST  = 3;
  localparam int unsigned RSC_B_LINK_TIMEOUT_TEST  = 4;
  localparam int unsigned RSC_B_LINK_TIMEOUT_RFR   = 5;
  localparam int unsigned RSC_B_DISP_IDLE  = 6;
  localparam int unsigned RSC_B_SCC_IRQ    = 7;
  localparam int unsigned RSC_B_LINK_VALID = 8;
  localparam int unsigned RSC_B_XFER_ACT   = 9;
  localparam int unsigned RSC_B_COMPLETION = 10;
  localparam int unsigned RSC_B_SRV_REQ    = 11;
  localparam int unsigned RSC_B_HOLD1      = 12;
  localparam int unsigned RSC_B_HOLD2      = 13;
  localparam int unsigned RSC_B_FAULT1     = 14;
  localparam int unsigned RSC_B_FAULT2     = 15;
  // read/write and write-only positions; the section id at 25 is read-only
  localparam int unsigned RSC_B_F1_FORCE   = 16;
  localparam int unsigned RSC_B_F2_FORCE   = 17;
  localparam int unsigned RSC_B_REQ_FORCE  = 18;
  localparam int unsigned RSC_B_CMP_FORCE  = 19;
  localparam int unsigned RSC_B_REFRAME    = 20;
  localparam int unsigned RSC_B_SELFTEST   = 21;
  localparam int unsigned RSC_B_CMP_CLEAR  = 22;
  localparam int unsigned RSC_B_REQ_CLEAR  = 23;
  localparam int unsigned RSC_B_STREAM_EN  = 24;
  localparam int unsigned RSC_B_SECTION_ID = 25;
  localparam int unsigned RSC_B_ERR_RESET  = 26;
  localparam int unsigned RSC_B_REQ_MASK   = 27;
  localparam int unsigned RSC_B_H1_MASK    = 28;
  localparam int unsigned RSC_B_H2_MASK    = 29;
  localparam int unsigned RSC_B_F1_MASK    = 30;
  localparam int unsigned RSC_B_F2_MASK    = 31;

  // reset values
  localparam logic [6:0]  RSC_ERR_RST  = 7'h00;
  localparam logic [3:0]  RSC_FORCE_RST = 4'h0;
  localparam logic [4:0]  RSC_MASK_RST = 5'h00;
  localparam logic [31:0] RSC_RDATA_RST = 32'h0000_0000;

  // front-end status lines of one section
  typedef struct packed {
    logic hold_first;
    logic hold_second;
    logic fault_first;
    logic fault_second;
  } rsc_fe_status_t;

  // serial receiver status of one section
  typedef struct packed {
    logic link_valid;
    logic transfer_active;
    logic reframe_done;
    logic selftest_pass;
    logic link_timeout;
    logic disparity_violation;
    logic buffer_overflow;
  } rsc_rx_status_t;

  // control lines towards the serial receiver
  typedef struct packed {
    logic reframe_mode;
    logic selftest_mode;
    logic logic_reset;
    logic stream_write_enable;
  } rsc_rx_ctrl_t;

  // front-panel indicators of one section
  typedef struct packed {
    logic link_lost_indicator;
    logic transfer_active;
    logic fe_fault_first;
    logic fe_fault_second;
    logic fe_hold_first;
    logic fe_hold_second;
    logic service_request;
  } rsc_panel_t;

  // open-collector line order inside a section
  localparam int unsigned RSC_OC_LINES = 5;
  localparam int unsigned RSC_OC_REQ   = 0;
  localparam int unsigned RSC_OC_H1    = 1;
  localparam int unsigned RSC_OC_H2    = 2;
  localparam int unsigned RSC_OC_F1    = 3;
  localparam int unsigned RSC_OC_F2    = 4;

endpackage : rsc_pkg

/* rsc_oc_drive.sv */
// rsc_oc_drive: registered open-collector pull-down drivers for wire-ORed lines.
// assumes the bus wire is pulled up outside; line reads low while any card pulls.
`timescale 1ns/1ps
module rsc_oc_drive
  import rsc_pkg::*;
#(
  parameter int unsigned LINES = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [LINES-1:0] assert_i,
  output logic      [LINES-1:0] pin_o,
  output logic      [LINES-1:0] pin_oe
);

  logic [LINES-1:0] drive_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_q <= '0;
    end else begin
      drive_q <= assert_i;
    end
  end

  assign pin_o  = '0;
  assign pin_oe = drive_q;

endmodule : rsc_oc_drive

/* rsc_csr.sv */
// rsc_csr: control/status registers of both readout sections of one card.
// assumes a card-level decoder gives one access at a time with a section select;
// front-end and receiver lines arrive synchronous to CLK_I.
`timescale 1ns/1ps
module rsc_csr
  import rsc_pkg::*;
(
  input  wire logic                              CLK_I,
  input  wire logic                              SYS_RST_I,
  // register port
  input  wire logic                              CSR_WR_I,
  input  wire logic                              CSR_RD_I,
  input  wire logic                              CSR_SECTION_I,
  input  wire logic [RSC_WIDTH-1:0]              CSR_WDATA_I,
  output logic      [RSC_WIDTH-1:0]              CSR_RDATA_O,
  output logic                                   CSR_ACK_O,
  // per-section status inputs
  input  wire rsc_fe_status_t [RSC_SECTIONS-1:0] FE_STATUS_I,
  input  wire rsc_rx_status_t [RSC_SECTIONS-1:0] RX_STATUS_I,
  input  wire logic           [RSC_SECTIONS-1:0] SERIAL_CTRL_IRQ_I,
  input  wire logic           [RSC_SECTIONS-1:0] REQUEST_SET_I,
  input  wire logic           [RSC_SECTIONS-1:0] COMPLETION_SET_I,
  // per-section outputs
  output rsc_rx_ctrl_t        [RSC_SECTIONS-1:0] RX_CTRL_O,
  output logic                [RSC_SECTIONS-1:0] COMPLETION_O,
  output rsc_panel_t          [RSC_SECTIONS-1:0] PANEL_O,
  // open-collector lines to the fan-out card, per section
  input  wire logic [RSC_SECTIONS*RSC_OC_LINES-1:0] FANOUT_LINE_I,
  output logic      [RSC_SECTIONS*RSC_OC_LINES-1:0] FANOUT_LINE_O,
  output logic      [RSC_SECTIONS*RSC_OC_LINES-1:0] FANOUT_LINE_OE
);

  logic [RSC_SECTIONS-1:0][RSC_WIDTH-1:0]    view;
  logic [RSC_SECTIONS-1:0][RSC_OC_LINES-1:0] oc_assert;

  for (genvar s = 0; s < RSC_SECTIONS; s++) begin : g_sec

    logic       wr;
    logic [6:0] err_q;
    logic [6:0] err_set;
    logic [3:0] force_q;
    logic [4:0] mask_q;
    logic       reframe_q;
    logic       selftest_q;
    logic       stream_en_q;
    logic       logic_rst_q;
    logic       cmp_q;
    logic       req_q;
    logic       completion;
    logic       request;
    logic       fault_first;
    logic       fault_second;
    logic       err_clear;
    rsc_panel_t panel_q;
    logic       cmp_out_q;

    assign wr        = CSR_WR_I && (CSR_SECTION_I == 1'(s));
    assign err_clear = wr && CSR_WDATA_I[RSC_B_ERR_RESET];

    always_comb begin
      err_set                  = '0;
      err_set[RSC_B_LINK_TIMEOUT_XFER] = RX_STATUS_I[s].link_timeout
                                 && RX_STATUS_I[s].transfer_active;
      err_set[RSC_B_DISP_XFER] = RX_STATUS_I[s].disparity_violation
                                 && RX_STATUS_I[s].transfer_active;
      err_set[RSC_B_OVF_XFER]  = RX_STATUS_I[s].buffer_overflow
                                 && RX_STATUS_I[s].transfer_active;
      err_set[RSC_B_DISP_TEST] = RX_STATUS_I[s].disparity_violation && selftest_q;
      err_set[RSC_B_LINK_TIMEOUT_TEST] = RX_STATUS_I[s].link_timeout && selftest_q;
      err_set[RSC_B_LINK_TIMEOUT_RFR]  = RX_STATUS_I[s].link_timeout && reframe_q;
      err_set[RSC_B_DISP_IDLE] = RX_STATUS_I[s].disparity_violation
                                 && !RX_STATUS_I[s].transfer_active;
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        err_q <= RSC_ERR_RST;
      end else begin
        err_q <= (err_clear ? 7'h00 : err_q) | err_set;
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        logic_rst_q <= 1'b0;
      end else begin
        logic_rst_q <= err_clear;
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        force_q     <= RSC_FORCE_RST;
        mask_q      <= RSC_MASK_RST;
        reframe_q   <= 1'b0;
        selftest_q  <= 1'b0;
        stream_en_q <= 1'b0;
      end else if (wr) begin
        force_q     <= CSR_WDATA_I[RSC_B_CMP_FORCE:RSC_B_F1_FORCE];
        mask_q      <= CSR_WDATA_I[RSC_B_F2_MASK:RSC_B_REQ_MASK];
        reframe_q   <= CSR_WDATA_I[RSC_B_REFRAME];
        selftest_q  <= CSR_WDATA_I[RSC_B_SELFTEST];
        stream_en_q <= CSR_WDATA_I[RSC_B_STREAM_EN];
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        cmp_q <= 1'b0;
      end else if (COMPLETION_SET_I[s]) begin
        cmp_q <= 1'b1;
      end else if (wr && CSR_WDATA_I[RSC_B_CMP_CLEAR]) begin
        cmp_q <= 1'b0;
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        req_q <= 1'b0;
      end else if (REQUEST_SET_I[s]) begin
        req_q <= 1'b1;
      end else if (wr && CSR_WDATA_I[RSC_B_REQ_CLEAR]) begin
        req_q <= 1'b0;
      end
    end

    assign completion  = cmp_q || force_q[RSC_B_CMP_FORCE - RSC_B_F1_FORCE];
    assign request     = req_q || force_q[RSC_B_REQ_FORCE - RSC_B_F1_FORCE];
    assign fault_first = FE_STATUS_I[s].fault_first
                         || force_q[RSC_B_F1_FORCE - RSC_B_F1_FORCE];
    assign fault_second = (FE_STATUS_I[s].fault_second
                           || force_q[RSC_B_F2_FORCE - RSC_B_F1_FORCE]
                           || err_q[RSC_B_LINK_TIMEOUT_XFER] || err_q[RSC_B_DISP_XFER]
                           || err_q[RSC_B_OVF_XFER])
                          && mask_q[RSC_B_F2_MASK - RSC_B_REQ_MASK];

    always_comb begin
      oc_assert[s]             = '0;
      oc_assert[s][RSC_OC_REQ] = request && mask_q[RSC_B_REQ_MASK - RSC_B_REQ_MASK];
      oc_assert[s][RSC_OC_H1]  = FE_STATUS_I[s].hold_first
                                 && mask_q[RSC_B_H1_MASK - RSC_B_REQ_MASK];
      oc_assert[s][RSC_OC_H2]  = FE_STATUS_I[s].hold_second
                                 && mask_q[RSC_B_H2_MASK - RSC_B_REQ_MASK];
      oc_assert[s][RSC_OC_F1]  = fault_first && mask_q[RSC_B_F1_MASK - RSC_B_REQ_MASK];
      oc_assert[s][RSC_OC_F2]  = fault_second;
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        cmp_out_q <= 1'b0;
      end else begin
        cmp_out_q <= completion;
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        panel_q <= '0;
      end else begin
        panel_q.link_lost_indicator <= !RX_STATUS_I[s].link_valid;
        panel_q.transfer_active     <= RX_STATUS_I[s].transfer_active;
        panel_q.fe_fault_first      <= fault_first;
        panel_q.fe_fault_second     <= fault_second;
        panel_q.fe_hold_first       <= FE_STATUS_I[s].hold_first;
        panel_q.fe_hold_second      <= FE_STATUS_I[s].hold_second;
        panel_q.service_request     <= request;
      end
    end

    // read view of this section
    always_comb begin
      view[s]                                    = '0;
      view[s][RSC_B_DISP_IDLE:RSC_B_LINK_TIMEOUT_XFER]   = err_q;
      view[s][RSC_B_SCC_IRQ]                     = SERIAL_CTRL_IRQ_I[s];
      view[s][RSC_B_LINK_VALID]                  = RX_STATUS_I[s].link_valid;
      view[s][RSC_B_XFER_ACT]                    = RX_STATUS_I[s].transfer_active;
      view[s][RSC_B_COMPLETION]                  = completion;
      view[s][RSC_B_SRV_REQ]                     = request;
      view[s][RSC_B_HOLD1]                       = FE_STATUS_I[s].hold_first;
      view[s][RSC_B_HOLD2]                       = FE_STATUS_I[s].hold_second;
      view[s][RSC_B_FAULT1]                      = fault_first;
      view[s][RSC_B_FAULT2]                      = fault_second;
      view[s][RSC_B_CMP_FORCE:RSC_B_F1_FORCE]    = force_q;
      view[s][RSC_B_REFRAME]                     = RX_STATUS_I[s].reframe_done;
      view[s][RSC_B_SELFTEST]                    = RX_STATUS_I[s].selftest_pass;
      view[s][RSC_B_STREAM_EN]                   = stream_en_q;
      view[s][RSC_B_SECTION_ID]                  = 1'(s);
      view[s][RSC_B_F2_MASK:RSC_B_REQ_MASK]      = mask_q;
    end

    assign RX_CTRL_O[s].reframe_mode        = reframe_q;
    assign RX_CTRL_O[s].selftest_mode       = selftest_q;
    assign RX_CTRL_O[s].logic_reset         = logic_rst_q;
    assign RX_CTRL_O[s].stream_write_enable = stream_en_q;
    assign COMPLETION_O[s]                  = cmp_out_q;
    assign PANEL_O[s]                       = panel_q;

  end : g_sec

  // register port answer
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CSR_RDATA_O <= RSC_RDATA_RST;
    end else if (CSR_RD_I) begin
      CSR_RDATA_O <= view[CSR_SECTION_I];
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CSR_ACK_O <= 1'b0;
    end else begin
      CSR_ACK_O <= CSR_RD_I || CSR_WR_I;
    end
  end

  rsc_oc_drive #(
    .LINES (RSC_SECTIONS*RSC_OC_LINES)
  ) u_oc (
    .clk_i    (CLK_I),
    .rst_i    (SYS_RST_I),
    .assert_i (oc_assert),
    .pin_o    (FANOUT_LINE_O),
    .pin_oe   (FANOUT_LINE_OE)
  );

endmodule : rsc_csr

/* rsc_csr_assertions.sv */
// rsc_csr_assertions: port-level checks of the section register block.
// assumes bind onto rsc_csr; one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module rsc_csr_checker
  import rsc_pkg::*;
(
  input wire logic                              CLK_I,
  input wire logic                              SYS_RST_I,
  input wire logic                              CSR_WR_I,
  input wire logic                              CSR_RD_I,
  input wire logic                              CSR_SECTION_I,
  input wire logic [RSC_WIDTH-1:0]              CSR_WDATA_I,
  input wire logic [RSC_WIDTH-1:0]              CSR_RDATA_O,
  input wire logic                              CSR_ACK_O,
  input wire rsc_rx_status_t [RSC_SECTIONS-1:0] RX_STATUS_I,
  input wire logic           [RSC_SECTIONS-1:0] SERIAL_CTRL_IRQ_I,
  input wire logic           [RSC_SECTIONS-1:0] COMPLETION_SET_I,
  input wire rsc_rx_ctrl_t   [RSC_SECTIONS-1:0] RX_CTRL_O,
  input wire logic           [RSC_SECTIONS-1:0] COMPLETION_O,
  input wire rsc_panel_t     [RSC_SECTIONS-1:0] PANEL_O,
  input wire logic [RSC_SECTIONS*RSC_OC_LINES-1:0] FANOUT_LINE_O,
  input wire logic [RSC_SECTIONS*RSC_OC_LINES-1:0] FANOUT_LINE_OE
);
  // inputs as seen at the previous edge
  logic                              sec_p;
  logic           [RSC_SECTIONS-1:0] irq_p;
  rsc_rx_status_t [RSC_SECTIONS-1:0] rx_p;
  always_ff @(posedge CLK_I) begin
    sec_p <= CSR_SECTION_I;
    irq_p <= SERIAL_CTRL_IRQ_I;
    rx_p  <= RX_STATUS_I;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_ack_after_req: assert property ((CSR_WR_I || CSR_RD_I) |=> CSR_ACK_O)
    else $error("no ack one cycle after access");
  a_section_id: assert property (CSR_RD_I |=> CSR_RDATA_O[25] == sec_p)
    else $error("section id bit wrong");
  a_strobe_zero: assert property (
    CSR_RD_I |=> !CSR_RDATA_O[22] && !CSR_RDATA_O[23] && !CSR_RDATA_O[26])
    else $error("strobe bit read nonzero");
  a_link_bit: assert property (
    CSR_RD_I |=> CSR_RDATA_O[8] == rx_p[sec_p].link_valid)
    else $error("link bit wrong");
  a_xfer_bit: assert property (
    CSR_RD_I |=> CSR_RDATA_O[9] == rx_p[sec_p].transfer_active)
    else $error("transfer bit wrong");
  a_irq_bit: assert property (CSR_RD_I |=> CSR_RDATA_O[7] == irq_p[sec_p])
    else $error("irq bit wrong");
  a_logic_reset: assert property (
    CSR_WR_I && CSR_WDATA_I[26] |=> RX_CTRL_O[sec_p].logic_reset)
    else $error("no receiver reset pulse");
  a_stream_enable: assert property (
    CSR_WR_I |=> RX_CTRL_O[sec_p].stream_write_enable == $past(CSR_WDATA_I[24]))
    else $error("stream enable wrong");
  a_completion_set: assert property (COMPLETION_SET_I[1] |-> ##2 COMPLETION_O[1])
    else $error("completion not driven");
  a_panel_link: assert property (
    !$past(SYS_RST_I) |-> PANEL_O[0].link_lost_indicator == !rx_p[0].link_valid)
    else $error("lost link indicator wrong");
  a_oc_low: assert property (FANOUT_LINE_O == '0)
    else $error("open-collector line driven high");
  a_req_masked: assert property (
    (CSR_WR_I && !CSR_SECTION_I && !CSR_WDATA_I[27]) ##1 !CSR_WR_I |=> !FANOUT_LINE_OE[0])
    else $error("request line pulled while masked");
  c_read_second: cover property (CSR_RD_I && CSR_SECTION_I);
  c_err_reset: cover property (CSR_WR_I && CSR_WDATA_I[26]);
  c_completion: cover property (COMPLETION_SET_I[1]);
endmodule : rsc_csr_checker

bind rsc_csr rsc_csr_checker u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CSR_WR_I(CSR_WR_I),
  .CSR_RD_I(CSR_RD_I), .CSR_SECTION_I(CSR_SECTION_I), .CSR_WDATA_I(CSR_WDATA_I),
  .CSR_RDATA_O(CSR_RDATA_O), .CSR_ACK_O(CSR_ACK_O), .RX_STATUS_I(RX_STATUS_I),
  .SERIAL_CTRL_IRQ_I(SERIAL_CTRL_IRQ_I), .COMPLETION_SET_I(COMPLETION_SET_I),
  .RX_CTRL_O(RX_CTRL_O), .COMPLETION_O(COMPLETION_O), .PANEL_O(PANEL_O),
  .FANOUT_LINE_O(FANOUT_LINE_O), .FANOUT_LINE_OE(FANOUT_LINE_OE));

/* rsc_host_model.sv */
// rsc_host_model: crate master on the strobe register port.
// assumes one access at a time; changes signals on falling edges.
`timescale 1ns/1ps
module rsc_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic             sec_o,
  output logic [31:0]      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    sec_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  task automatic access(input logic w, input logic s, input logic [31:0] d, output bit ok);
    @(negedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    sec_o <= s;
    wdata_o <= d;
    ok = 1'b0;
    // strobe is a one-cycle pulse; ack stands in the cycle after it
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      ok = (ack_i === 1'b1);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      // released qualifiers no longer show the last value
      sec_o <= !s;
      wdata_o <= ~d;
    end
  endtask : access
endmodule : rsc_host_model

/* tb_top.sv */
// tb_top: self-checking bench for the two section registers.
// assumes rsc_csr and rsc_host_model; inputs change on falling edges.
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  logic                 CLK_I, SYS_RST_I, wr, rd, sec, ack, rd_d, ok, s0;
  logic [31:0]          wd, rdata, w, seed, vx;
  rsc_fe_status_t [1:0] fe;
  rsc_rx_status_t [1:0] rx;
  rsc_rx_ctrl_t   [1:0] rxc;
  rsc_panel_t     [1:0] pnl;
  logic [1:0]           irq, rset, cset, cmp;
  logic [9:0]           flo, floe;
  logic [31:0]          exp_q[$], msk_q[$];
  int                   fails, cmp_count;
  logic [31:0] mw[7] = '{0, 0, 0, 32'h0020_0000, 32'h0020_0000, 32'h0010_0000, 0};
  logic [6:0]  mr[7] = '{7'h64, 7'h62, 7'h61, 7'h42, 7'h44, 7'h44, 7'h42};

  rsc_host_model host (.clk_i(CLK_I), .ack_i(ack), .wr_o(wr), .rd_o(rd), .sec_o(sec),
    .wdata_o(wd));
  rsc_csr dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CSR_WR_I(wr), .CSR_RD_I(rd),
    .CSR_SECTION_I(sec), .CSR_WDATA_I(wd), .CSR_RDATA_O(rdata), .CSR_ACK_O(ack),
    .FE_STATUS_I(fe), .RX_STATUS_I(rx), .SERIAL_CTRL_IRQ_I(irq), .REQUEST_SET_I(rset),
    .COMPLETION_SET_I(cset), .RX_CTRL_O(rxc), .COMPLETION_O(cmp), .PANEL_O(pnl),
    .FANOUT_LINE_I(10'h000), .FANOUT_LINE_O(flo), .FANOUT_LINE_OE(floe));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic acc(input logic iw, input logic s, input logic [31:0] d);
    host.access(iw, s, d, ok);
    if (!ok) begin
      fails++;
      results();
    end
  endtask : acc
  task automatic rd_csr(input logic s, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    acc(1'b0, s, 32'h0000_0000);
  endtask : rd_csr
  // expected read view with all error inputs quiet
  function automatic logic [31:0] view(input logic s, input logic [31:0] cw);
    logic [31:0] v;
    v = cw & 32'hf90f_0000;
    v[7] = irq[s];
    v[8] = rx[s].link_valid;
    v[9] = rx[s].transfer_active;
    v[12] = fe[s].hold_first;
    v[13] = fe[s].hold_second;
    v[14] = fe[s].fault_first | cw[16];
    v[15] = (fe[s].fault_second | cw[17]) & cw[31];
    v[20] = rx[s].reframe_done;
    v[21] = rx[s].selftest_pass;
    v[25] = s;
    return v;
  endfunction : view

  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  // read strobe as taken by the design at the rising edge
  always @(posedge CLK_I) begin
    rd_d <= rd;
  end
  // read results matched against the oldest note
  always @(negedge CLK_I) begin
    if (ack === 1'b1 && rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
      end else begin
        check(rdata & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge CLK_I);
    fails++;
    results();
  end
  initial begin
    {SYS_RST_I, fails, cmp_count, seed} = {1'b1, 64'h0, 32'h0001_0773};
    {fe, rx, irq, rset, cset} = '0;
    repeat (16) @(negedge CLK_I);
    SYS_RST_I <= 1'b0;
    rd_csr(1'b0, 32'h0000_0000, 32'hffff_ffff);
    rd_csr(1'b1, 32'h0200_0000, 32'hffff_ffff);
    for (int i = 0; i < 12; i++) begin
      w = xs();
      s0 = w[0];
      fe[s0] <= w[4:1];
      rx[s0] <= {w[8:5], 3'b000};
      irq[s0] <= w[9];
      w = xs() & 32'hfff3_ffff;
      acc(1'b1, s0, w);
      vx = view(s0, w);
      rd_csr(s0, vx, 32'hffff_ffff);
      check(floe[s0*5 +: 5], {vx[15], vx[14] & w[30], fe[s0].hold_second & w[29],
        fe[s0].hold_first & w[28], 1'b0});
      check(pnl[s0], {!rx[s0].link_valid, rx[s0].transfer_active, vx[14], vx[15],
        fe[s0].hold_first, fe[s0].hold_second, 1'b0});
      check(rxc[s0], {w[20], w[21], 1'b0, w[24]});
    end
    {fe, rx, irq} <= '0;
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, 1'b0, mw[i] | 32'h8400_0000);
      rx[0] <= mr[i];
      @(negedge CLK_I) rx[0] <= 7'h40;
      rd_csr(1'b0, (32'h1 << i) | ((i < 3) ? 32'h0000_8000 : 32'h0000_0000),
        (32'h1 << i) | 32'h0000_8000);
    end
    acc(1'b1, 1'b0, 32'h0400_0000);
    rd_csr(1'b0, 32'h0000_0000, 32'h0000_807f);
    acc(1'b1, 1'b1, 32'h0800_0000);
    {rset[1], cset[1]} <= 2'b11;
    @(negedge CLK_I) {rset[1], cset[1]} <= 2'b00;
    rd_csr(1'b1, 32'h0000_0c00, 32'h0000_0c00);
    check(floe[5], 1'b1);
    check(cmp[1], 1'b1);
    acc(1'b1, 1'b1, 32'h00c0_0000);
    rd_csr(1'b1, 32'h0000_0000, 32'h0000_0c00);
    check({floe[5], cmp[1]}, 2'b00);
    acc(1'b1, 1'b1, 32'h000f_0000);
    rd_csr(1'b1, 32'h000f_4000, 32'h000f_4000);
    check(cmp[1], 1'b1);
    repeat (3) @(negedge CLK_I);
    results();
  end
endmodule : tb_top
